// ==== rtl/ppt_regs.svh ====
// Register offsets, field positions, codes and reset values of the period timer and capture unit.
`ifndef PPT_REGS_SVH
`define PPT_REGS_SVH
`define PPT_ADDR_W 8
`define PPT_OFS_COUNT 8'h00
`define PPT_OFS_LIMIT 8'h04
`define PPT_OFS_TCTL 8'h08
`define PPT_OFS_UCTL 8'h0C
`define PPT_OFS_DLO 8'h10
`define PPT_OFS_DHI 8'h14
`define PPT_OFS_FLAG 8'h18
`define PPT_OFS_ENA 8'h1C
`define PPT_COUNT_RST 8'h00
`define PPT_LIMIT_RST 8'hFF
`define PPT_TCTL_MASK 8'h7F
`define PPT_UCTL_MASK 6'h3F
`define PPT_FLAG_PERIOD_BIT 1
`define PPT_FLAG_UNIT_BIT 2
`define PPT_QPHASE_LAST 2'h3
`define PPT_PRE_DIV1 2'h0
`define PPT_PRE_DIV4 2'h1
`define PPT_PRE_DIV4_LAST 4'h3
`define PPT_PRE_DIV16_LAST 4'hF
`define PPT_ECNT_4TH_LAST 4'h3
`define PPT_ECNT_16TH_LAST 4'hF
`define PPT_MODE_OFF 4'h0
`define PPT_MODE_TOGGLE 4'h2
`define PPT_MODE_CAP_FALL 4'h4
`define PPT_MODE_CAP_RISE 4'h5
`define PPT_MODE_CAP_4TH 4'h6
`define PPT_MODE_CAP_16TH 4'h7
`define PPT_MODE_SET_HIGH 4'h8
`define PPT_MODE_SET_LOW 4'h9
`define PPT_MODE_SOFT_IRQ 4'hA
`define PPT_MODE_SPECIAL 4'hB
`endif

// ==== rtl/ppt_pkg.sv ====
// Types shared by the period timer and capture unit.
package ppt_pkg;
	typedef struct packed {
		logic unused;
		logic [3:0] postscale;
		logic run;
		logic [1:0] prescale;
	} ppt_tctl_s;
	typedef struct packed {
		logic [1:0] duty_low_bits;
		logic [3:0] unit_mode_field;
	} ppt_uctl_s;
	typedef enum {UC_OFF, UC_RESERVED, UC_CAPTURE, UC_COMPARE, UC_PWM} ppt_uclass_e;
	function automatic ppt_uclass_e ppt_classify(input logic [3:0] mode);
		ppt_uclass_e c;
		c = UC_OFF;
		case (mode[3:2])
			2'h0: c = (mode == 4'h0) ? UC_OFF : ((mode == 4'h2) ? UC_COMPARE : UC_RESERVED);
			2'h1: c = UC_CAPTURE;
			2'h2: c = UC_COMPARE;
			default: c = UC_PWM;
		endcase
		return c;
	endfunction : ppt_classify
endpackage : ppt_pkg

// ==== rtl/ppt_unit.sv ====
// Period timer with postscaled flag, and capture/compare/PWM unit behind an APB slave.
//
// Our own choices: the APB slave port and the address map.
`include "ppt_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module ppt_unit
	import ppt_pkg::*;
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PPT_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Companion timer
	input wire logic [15:0] companion_timer_count,
	input wire logic companion_sync,
	output logic companion_reset,
	output logic conversion_start,
	// Unit pin
	input wire logic unit_pin_in,
	output logic unit_pin_out,
	output logic unit_pin_oe_n,
	// Events and flags
	output logic period_match,
	output logic period_irq_req,
	output logic unit_irq_req
);
	import ppt_pkg::*;

	logic [1:0] phase_q, phase_d;
	logic [3:0] pre_q, pre_d;
	logic [3:0] post_q, post_d;
	logic [7:0] count_q, count_d;
	logic [7:0] limit_q, limit_d;
	logic [7:0] tctl_q, tctl_d;
	logic [5:0] uctl_q, uctl_d;
	logic [7:0] dlo_q, dlo_d;
	logic [7:0] dhi_q, dhi_d;
	logic [3:0] ecnt_q, ecnt_d;
	logic [9:0] duty_q, duty_d;
	logic pflag_q, pflag_d;
	logic uflag_q, uflag_d;
	logic pen_q, pen_d;
	logic uen_q, uen_d;
	logic pin_q, pin_d;
	logic cmp_eq_q, cmp_eq_d;
	logic match_q, match_d;
	logic sevt_q, sevt_d;
	logic sync1_q, sync2_q, sync3_q;
	logic [31:0] prdata_q, prdata_d;

	ppt_tctl_s tctl;
	ppt_uctl_s uctl;
	ppt_uclass_e ucls;
	logic wr, rd_setup, mapped;
	logic tick, ps_hit, match_now, post_hit;
	logic rise, fall, cap_evt, cmp_now, cmp_evt;
	logic [3:0] wmode;

	assign tctl = ppt_tctl_s'(tctl_q);
	assign uctl = ppt_uctl_s'(uctl_q);
	assign ucls = ppt_classify(uctl.unit_mode_field);
	assign wr = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;
	assign wmode = pwdata[3:0];

	always_comb
	begin
		case (paddr)
			`PPT_OFS_COUNT, `PPT_OFS_LIMIT, `PPT_OFS_TCTL, `PPT_OFS_UCTL,
			`PPT_OFS_DLO, `PPT_OFS_DHI, `PPT_OFS_FLAG, `PPT_OFS_ENA: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Zero wait states: read data is registered in the setup cycle.
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_q;

	always_comb
	begin
		prdata_d = prdata_q;
		if (rd_setup)
		begin
			case (paddr)
				`PPT_OFS_COUNT: prdata_d = {24'h000000, count_q};
				`PPT_OFS_LIMIT: prdata_d = {24'h000000, limit_q};
				`PPT_OFS_TCTL: prdata_d = {24'h000000, tctl_q};
				`PPT_OFS_UCTL: prdata_d = {26'h0000000, uctl_q};
				`PPT_OFS_DLO: prdata_d = {24'h000000, dlo_q};
				`PPT_OFS_DHI: prdata_d = {24'h000000, dhi_q};
				`PPT_OFS_FLAG: prdata_d = {29'h00000000, uflag_q, pflag_q, 1'b0};
				`PPT_OFS_ENA: prdata_d = {29'h00000000, uen_q, pen_q, 1'b0};
				default: prdata_d = 32'h00000000;
			endcase
		end
	end

	// Instruction clock is the bus clock divided by four.
	assign tick = (phase_q == `PPT_QPHASE_LAST) & tctl.run;
	always_comb
	begin
		case (tctl.prescale)
			`PPT_PRE_DIV1: ps_hit = tick;
			`PPT_PRE_DIV4: ps_hit = tick & (pre_q[1:0] == 2'(`PPT_PRE_DIV4_LAST));
			default: ps_hit = tick & (pre_q == `PPT_PRE_DIV16_LAST);
		endcase
	end
	assign match_now = ps_hit & (count_q == limit_q);
	assign post_hit = match_now & (post_q == tctl.postscale);

	// Capture edge detection reads only the second and third sync stages.
	assign rise = sync2_q & ~sync3_q;
	assign fall = ~sync2_q & sync3_q;
	always_comb
	begin
		cap_evt = 1'b0;
		case (uctl.unit_mode_field)
			`PPT_MODE_CAP_FALL: cap_evt = fall;
			`PPT_MODE_CAP_RISE: cap_evt = rise;
			`PPT_MODE_CAP_4TH: cap_evt = rise & (ecnt_q[1:0] == 2'(`PPT_ECNT_4TH_LAST));
			`PPT_MODE_CAP_16TH: cap_evt = rise & (ecnt_q == `PPT_ECNT_16TH_LAST);
			default: cap_evt = 1'b0;
		endcase
		cap_evt = cap_evt & companion_sync;
	end
	assign cmp_now = (companion_timer_count == {dhi_q, dlo_q});
	assign cmp_evt = cmp_now & ~cmp_eq_q & (ucls == UC_COMPARE);

	always_comb
	begin
		phase_d = phase_q + 2'h1;
		pre_d = pre_q;
		post_d = post_q;
		count_d = count_q;
		limit_d = limit_q;
		tctl_d = tctl_q;
		uctl_d = uctl_q;
		dlo_d = dlo_q;
		dhi_d = dhi_q;
		ecnt_d = ecnt_q;
		duty_d = duty_q;
		pflag_d = pflag_q;
		uflag_d = uflag_q;
		pen_d = pen_q;
		uen_d = uen_q;
		pin_d = pin_q;
		cmp_eq_d = cmp_now;
		match_d = 1'b0;
		sevt_d = 1'b0;
		// Period timer.
		if (tick)
			pre_d = pre_q + 4'h1;
		if (ps_hit)
			count_d = match_now ? `PPT_COUNT_RST : count_q + 8'h01;
		if (match_now)
		begin
			match_d = 1'b1;
			post_d = post_hit ? 4'h0 : post_q + 4'h1;
		end
		if (wr && paddr == `PPT_OFS_COUNT)
		begin
			count_d = pwdata[7:0];
			pre_d = 4'h0;
			post_d = 4'h0;
		end
		if (wr && paddr == `PPT_OFS_TCTL)
		begin
			tctl_d = pwdata[7:0] & `PPT_TCTL_MASK;
			count_d = count_q;
			pre_d = 4'h0;
			post_d = 4'h0;
		end
		if (wr && paddr == `PPT_OFS_LIMIT)
			limit_d = pwdata[7:0];
		// Capture edge prescaler.
		if (ucls != UC_CAPTURE)
			ecnt_d = 4'h0;
		else if (rise && uctl.unit_mode_field[1] && companion_sync)
			ecnt_d = cap_evt ? 4'h0 : ecnt_q + 4'h1;
		// Compare actions: pin changes, or the special event.
		if (cmp_evt)
		begin
			case (uctl.unit_mode_field)
				`PPT_MODE_TOGGLE: pin_d = ~pin_q;
				`PPT_MODE_SET_HIGH: pin_d = 1'b1;
				`PPT_MODE_SET_LOW: pin_d = 1'b0;
				`PPT_MODE_SPECIAL: sevt_d = 1'b1;
				default: pin_d = pin_q;
			endcase
		end
		// PWM: the period restart sets the pin unless the new duty is zero, and reloads the duty buffer.
		if (ucls == UC_PWM)
		begin
			if (match_now)
			begin
				duty_d = {dlo_q, uctl.duty_low_bits};
				dhi_d = dlo_q;
				pin_d = ({dlo_q, uctl.duty_low_bits} != 10'h000);
			end
			else if (duty_q == {count_q, phase_q})
				pin_d = 1'b0;
		end
		// Capture overwrites whatever the pair held.
		if (cap_evt)
		begin
			dlo_d = companion_timer_count[7:0];
			dhi_d = companion_timer_count[15:8];
		end
		if (wr && paddr == `PPT_OFS_DLO)
			dlo_d = pwdata[7:0];
		// The high byte is read-only while PWM owns it.
		if (wr && paddr == `PPT_OFS_DHI && ucls != UC_PWM)
			dhi_d = pwdata[7:0];
		if (wr && paddr == `PPT_OFS_UCTL)
		begin
			uctl_d = pwdata[5:0] & `PPT_UCTL_MASK;
			case (wmode)
				`PPT_MODE_OFF: pin_d = 1'b0;
				`PPT_MODE_SET_HIGH: pin_d = 1'b0;
				`PPT_MODE_SET_LOW: pin_d = 1'b1;
				default: pin_d = pin_d;
			endcase
			if (wmode == `PPT_MODE_OFF)
			begin
				ecnt_d = 4'h0;
				duty_d = 10'h000;
			end
		end
		if (wr && paddr == `PPT_OFS_ENA)
		begin
			pen_d = pwdata[`PPT_FLAG_PERIOD_BIT];
			uen_d = pwdata[`PPT_FLAG_UNIT_BIT];
		end
		// Flags: software writes zero to clear, a same-cycle set wins.
		if (wr && paddr == `PPT_OFS_FLAG)
		begin
			pflag_d = pflag_q & pwdata[`PPT_FLAG_PERIOD_BIT];
			uflag_d = uflag_q & pwdata[`PPT_FLAG_UNIT_BIT];
		end
		if (post_hit)
			pflag_d = 1'b1;
		if (cap_evt || cmp_evt)
			uflag_d = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_q <= 2'h0;
			pre_q <= 4'h0;
			post_q <= 4'h0;
			count_q <= `PPT_COUNT_RST;
			limit_q <= `PPT_LIMIT_RST;
			tctl_q <= 8'h00;
			uctl_q <= 6'h00;
			dlo_q <= 8'h00;
			dhi_q <= 8'h00;
			ecnt_q <= 4'h0;
			duty_q <= 10'h000;
			pflag_q <= 1'b0;
			uflag_q <= 1'b0;
			pen_q <= 1'b0;
			uen_q <= 1'b0;
			pin_q <= 1'b0;
			cmp_eq_q <= 1'b0;
			match_q <= 1'b0;
			sevt_q <= 1'b0;
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			phase_q <= phase_d;
			pre_q <= pre_d;
			post_q <= post_d;
			count_q <= count_d;
			limit_q <= limit_d;
			tctl_q <= tctl_d;
			uctl_q <= uctl_d;
			dlo_q <= dlo_d;
			dhi_q <= dhi_d;
			ecnt_q <= ecnt_d;
			duty_q <= duty_d;
			pflag_q <= pflag_d;
			uflag_q <= uflag_d;
			pen_q <= pen_d;
			uen_q <= uen_d;
			pin_q <= pin_d;
			cmp_eq_q <= cmp_eq_d;
			match_q <= match_d;
			sevt_q <= sevt_d;
			sync1_q <= unit_pin_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			prdata_q <= prdata_d;
		end
	end

	// The pin is driven only in the toggle, set-high and set-low compare modes and PWM; capture keeps listening.
	assign unit_pin_out = pin_q;
	assign unit_pin_oe_n = ~((ucls == UC_PWM) || (uctl.unit_mode_field == `PPT_MODE_TOGGLE)
		|| (uctl.unit_mode_field == `PPT_MODE_SET_HIGH)
		|| (uctl.unit_mode_field == `PPT_MODE_SET_LOW));
	assign period_match = match_q;
	assign companion_reset = sevt_q;
	assign conversion_start = sevt_q;
	assign period_irq_req = pflag_q & pen_q;
	assign unit_irq_req = uflag_q & uen_q;

	property p_div1_step;
		@(posedge pclk) disable iff (!presetn)
		(tick && tctl.prescale == 2'h0 && !wr && count_q != limit_q) |=> count_q == $past(count_q) + 8'h01;
	endproperty
	a_div1_step: assert property (p_div1_step) else $error("count missed a divide-by-one tick");

	property p_match_wrap;
		@(posedge pclk) disable iff (!presetn)
		(match_q && !$past(wr)) |-> ($past(count_q) == $past(limit_q)) && count_q == 8'h00;
	endproperty
	a_match_wrap: assert property (p_match_wrap) else $error("match pulse without wrap to zero");

	property p_reset_values;
		@(posedge pclk) $rose(presetn) |-> count_q == 8'h00 && limit_q == 8'hFF;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("wrong period reset values");

	property p_ctl_clears;
		@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `PPT_OFS_TCTL) |=> pre_q == 4'h0 && post_q == 4'h0 && count_q == $past(count_q);
	endproperty
	a_ctl_clears: assert property (p_ctl_clears) else $error("control write mishandled counters");

	property p_stopped_holds;
		@(posedge pclk) disable iff (!presetn)
		(!tctl.run && !wr) [*2] |-> $stable(count_q) && $stable(pre_q) && !match_q;
	endproperty
	a_stopped_holds: assert property (p_stopped_holds) else $error("stopped timer moved");

	property p_post_ratio;
		@(posedge pclk) disable iff (!presetn)
		$rose(pflag_q) |-> $past(match_now) && $past(post_q) == $past(tctl.postscale);
	endproperty
	a_post_ratio: assert property (p_post_ratio) else $error("period flag off the postscale ratio");

	property p_capture_copy;
		@(posedge pclk) disable iff (!presetn)
		(cap_evt && !wr) |=> {dhi_q, dlo_q} == $past(companion_timer_count) && uflag_q;
	endproperty
	a_capture_copy: assert property (p_capture_copy) else $error("capture did not copy timer");

	property p_edge_clear;
		@(posedge pclk) disable iff (!presetn)
		(ucls != UC_CAPTURE) |=> ecnt_q == 4'h0;
	endproperty
	a_edge_clear: assert property (p_edge_clear) else $error("edge prescaler not cleared");

	property p_off_quiet;
		@(posedge pclk) disable iff (!presetn)
		(ucls == UC_OFF) |-> unit_pin_oe_n && !companion_reset ##1 (ucls != UC_OFF || ecnt_q == 4'h0);
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("disabled unit still active");

	c_capture: cover property (@(posedge pclk) disable iff (!presetn) cap_evt);
	c_period_flag: cover property (@(posedge pclk) disable iff (!presetn) $rose(pflag_q));
	c_compare: cover property (@(posedge pclk) disable iff (!presetn) cmp_evt);
	c_special: cover property (@(posedge pclk) disable iff (!presetn) companion_reset);
endmodule : ppt_unit
`default_nettype wire

// ==== dv/ppt_pin_src.sv ====
// External signal source that toggles the capture pin a commanded number of times.
`timescale 1ns/10ps
`default_nettype none
module ppt_pin_src
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Command
	input wire logic go,
	input wire logic [5:0] n_edges,
	// Pin and status
	output logic pin,
	output logic busy
);
	logic [5:0] left_q;
	logic [5:0] left_d;
	logic [2:0] gap_q;
	logic [2:0] gap_d;
	logic pin_q;
	logic pin_d;
	// Each level holds eight cycles, so every edge clears the pin synchroniser.
	always_comb
	begin
		left_d = left_q;
		gap_d = gap_q;
		pin_d = pin_q;
		if (go)
		begin
			left_d = n_edges;
			gap_d = 3'h0;
		end
		else if (left_q != 6'h00)
		begin
			gap_d = gap_q + 3'h1;
			if (gap_q == 3'h7)
			begin
				pin_d = ~pin_q;
				left_d = left_q - 6'h01;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			left_q <= 6'h00;
			gap_q <= 3'h0;
			pin_q <= 1'b0;
		end
		else
		begin
			left_q <= left_d;
			gap_q <= gap_d;
			pin_q <= pin_d;
		end
	end
	assign pin = pin_q;
	assign busy = go | (left_q != 6'h00);
endmodule : ppt_pin_src
`default_nettype wire

// ==== dv/tb_period_timer_and_capture_unit.sv ====
// Self-checking testbench of the period timer and capture unit.
`include "ppt_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_period_timer_and_capture_unit;
	logic pclk, presetn, psel, penable, pwrite, go, companion_sync;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic pready, pslverr, serr, companion_reset, conversion_start;
	logic unit_pin_in, unit_pin_out, unit_pin_oe_n;
	logic period_match, period_irq_req, unit_irq_req, busy, seen_r, seen_c;
	logic [15:0] cval;
	logic [5:0] n_edges;
	logic [3:0] m;
	logic [3:0] modes [5] = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB};
	int errors, checks_done, k, w;
	ppt_unit i_ppt_unit(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .companion_timer_count(cval), .companion_sync(companion_sync),
		.companion_reset(companion_reset), .conversion_start(conversion_start),
		.unit_pin_in(unit_pin_in), .unit_pin_out(unit_pin_out), .unit_pin_oe_n(unit_pin_oe_n),
		.period_match(period_match), .period_irq_req(period_irq_req),
		.unit_irq_req(unit_irq_req));
	ppt_pin_src i_ppt_pin_src(.pclk(pclk), .presetn(presetn), .go(go), .n_edges(n_edges),
		.pin(unit_pin_in), .busy(busy));
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task finish_test;
		if (errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	task check(input string name, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : cyc
	// The master never assumes zero wait states, although this slave answers at once.
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 64);
		if (n >= 64)
		begin
			errors++;
			finish_test();
		end
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h000000, d});
	endtask : wr
	task rd(input string name, input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h00000000);
		check(name, rdat, {24'h000000, e});
	endtask : rd
	task set_mode(input logic [3:0] md);
		wr(`PPT_OFS_UCTL, {4'h0, md});
	endtask : set_mode
	task period(input int exp);
		k = 0;
		while (period_match !== 1'b1 && k < 1000)
		begin
			cyc(1);
			k++;
		end
		cyc(1);
		k = 1;
		while (period_match !== 1'b1 && k < 1000)
		begin
			cyc(1);
			k++;
		end
		check("match spacing", 32'(k), 32'(exp));
	endtask : period
	task cap(input logic [5:0] n, input logic e);
		@(posedge pclk);
		go <= 1'b1;
		n_edges <= n;
		@(posedge pclk);
		go <= 1'b0;
		cyc(1);
		w = 0;
		while (busy === 1'b1 && w < 1000)
		begin
			cyc(1);
			w++;
		end
		cyc(6);
		apb(1'b0, `PPT_OFS_FLAG, 32'h00000000);
		check("unit flag", 32'(rdat[`PPT_FLAG_UNIT_BIT]), 32'(e));
	endtask : cap
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		go = 1'b0;
		n_edges = 6'h00;
		cval = 16'h0000;
		companion_sync = 1'b1;
		errors = 0;
		checks_done = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd("count", `PPT_OFS_COUNT, 8'h00);
		rd("limit", `PPT_OFS_LIMIT, 8'hFF);
		apb(1'b0, 8'h20, 32'h00000000);
		check("slave error", 32'(serr), 32'h00000001);
		wr(`PPT_OFS_TCTL, 8'hFF);
		rd("timer control", `PPT_OFS_TCTL, 8'h7F);
		wr(`PPT_OFS_UCTL, 8'hFF);
		rd("unit control", `PPT_OFS_UCTL, 8'h3F);
		wr(`PPT_OFS_UCTL, 8'h00);
		wr(`PPT_OFS_LIMIT, 8'h02);
		wr(`PPT_OFS_COUNT, 8'h00);
		for (int p = 0; p < 4; p++)
		begin
			wr(`PPT_OFS_TCTL, 8'h04 | 8'(p));
			period(12 * ((p == 0) ? 1 : ((p == 1) ? 4 : 16)));
		end
		wr(`PPT_OFS_TCTL, 8'h00);
		wr(`PPT_OFS_FLAG, 8'h00);
		wr(`PPT_OFS_ENA, 8'h02);
		wr(`PPT_OFS_TCTL, 8'h1C);
		k = 0;
		w = 0;
		while (period_irq_req !== 1'b1 && w < 2000)
		begin
			cyc(1);
			if (period_match === 1'b1)
				k++;
			w++;
		end
		check("postscale", 32'(k), 32'h00000004);
		wr(`PPT_OFS_ENA, 8'h00);
		cyc(1);
		check("period irq masked", 32'(period_irq_req), 32'h00000000);
		wr(`PPT_OFS_TCTL, 8'h00);
		wr(`PPT_OFS_COUNT, 8'h01);
		k = 0;
		repeat (100)
		begin
			cyc(1);
			if (period_match === 1'b1)
				k++;
		end
		check("stopped matches", 32'(k), 32'h00000000);
		rd("held count", `PPT_OFS_COUNT, 8'h01);
		wr(`PPT_OFS_TCTL, 8'h02);
		rd("count kept", `PPT_OFS_COUNT, 8'h01);
		set_mode(`PPT_MODE_CAP_RISE);
		wr(`PPT_OFS_FLAG, 8'h00);
		cval <= 16'h1234;
		cap(6'd1, 1'b1);
		rd("data low", `PPT_OFS_DLO, 8'h34);
		rd("data high", `PPT_OFS_DHI, 8'h12);
		wr(`PPT_OFS_ENA, 8'h04);
		cyc(1);
		check("unit irq", 32'(unit_irq_req), 32'h00000001);
		wr(`PPT_OFS_ENA, 8'h00);
		cval <= 16'hBEEF;
		cap(6'd2, 1'b1);
		rd("overwrite low", `PPT_OFS_DLO, 8'hEF);
		rd("overwrite high", `PPT_OFS_DHI, 8'hBE);
		// The interrupt enable stays clear across every mode change below.
		set_mode(`PPT_MODE_CAP_FALL);
		wr(`PPT_OFS_FLAG, 8'h00);
		cval <= 16'h1111;
		cap(6'd1, 1'b1);
		rd("falling capture", `PPT_OFS_DLO, 8'h11);
		wr(`PPT_OFS_FLAG, 8'h00);
		cap(6'd1, 1'b0);
		set_mode(`PPT_MODE_OFF);
		set_mode(`PPT_MODE_CAP_4TH);
		wr(`PPT_OFS_FLAG, 8'h00);
		cap(6'd6, 1'b0);
		cap(6'd2, 1'b1);
		wr(`PPT_OFS_FLAG, 8'h00);
		cap(6'd4, 1'b0);
		set_mode(`PPT_MODE_OFF);
		set_mode(`PPT_MODE_CAP_4TH);
		wr(`PPT_OFS_FLAG, 8'h00);
		cap(6'd6, 1'b0);
		cap(6'd2, 1'b1);
		set_mode(`PPT_MODE_OFF);
		set_mode(`PPT_MODE_CAP_4TH);
		wr(`PPT_OFS_FLAG, 8'h00);
		cap(6'd4, 1'b0);
		set_mode(`PPT_MODE_CAP_16TH);
		wr(`PPT_OFS_FLAG, 8'h00);
		cap(6'd26, 1'b0);
		cap(6'd2, 1'b1);
		set_mode(`PPT_MODE_CAP_RISE);
		companion_sync <= 1'b0;
		wr(`PPT_OFS_FLAG, 8'h00);
		cap(6'd2, 1'b0);
		companion_sync <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			m = modes[i];
			set_mode(`PPT_MODE_OFF);
			cval <= 16'h0040;
			wr(`PPT_OFS_DLO, 8'h50);
			wr(`PPT_OFS_DHI, 8'h00);
			set_mode(m);
			wr(`PPT_OFS_FLAG, 8'h00);
			seen_r = 1'b0;
			seen_c = 1'b0;
			cval <= 16'h0050;
			repeat (6)
			begin
				cyc(1);
				if (companion_reset === 1'b1)
					seen_r = 1'b1;
				if (conversion_start === 1'b1)
					seen_c = 1'b1;
			end
			apb(1'b0, `PPT_OFS_FLAG, 32'h00000000);
			check("compare flag", 32'(rdat[`PPT_FLAG_UNIT_BIT]), 32'h00000001);
			check("pin enable", 32'(unit_pin_oe_n), 32'(m == 4'hA || m == 4'hB));
			if (m != 4'hA && m != 4'hB)
				check("pin level", 32'(unit_pin_out), 32'(m != 4'h9));
			check("timer reset", 32'(seen_r), 32'(m == 4'hB));
			check("conversion", 32'(seen_c), 32'(m == 4'hB));
		end
		// PWM with duty 0x01:10 on a period of three counts at prescale one.
		wr(`PPT_OFS_DLO, 8'h01);
		wr(`PPT_OFS_UCTL, 8'h2C);
		wr(`PPT_OFS_TCTL, 8'h04);
		cyc(30);
		rd("duty latch", `PPT_OFS_DHI, 8'h01);
		wr(`PPT_OFS_DHI, 8'hAA);
		rd("duty latch kept", `PPT_OFS_DHI, 8'h01);
		check("pwm pin enable", 32'(unit_pin_oe_n), 32'h00000000);
		seen_r = 1'b0;
		seen_c = 1'b0;
		repeat (24)
		begin
			cyc(1);
			if (unit_pin_out === 1'b1)
				seen_r = 1'b1;
			if (unit_pin_out === 1'b0)
				seen_c = 1'b1;
		end
		check("pwm high", 32'(seen_r), 32'h00000001);
		check("pwm low", 32'(seen_c), 32'h00000001);
		finish_test();
	end
	initial
	begin
		repeat (60000) @(posedge pclk);
		errors++;
		finish_test();
	end
endmodule : tb_period_timer_and_capture_unit
`default_nettype wire
